// file: logic/bghc_pkg.sv
// Package for the boost gate-drive and hiccup controller.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
package bghc_pkg;
  localparam int CLK_PERIOD_PS        = 5000;
  localparam int REPLENISH_TIME_PS    = 75000;
  localparam int REPLENISH_CYCLES     = (REPLENISH_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REPL_PER_SET         = 4;
  localparam int REPL_SETS            = 4;
  localparam int HICCUP_SW_CYCLES     = 512;
  localparam int CNT_W                = 16;
  localparam int DEGLITCH_W           = 8;
  localparam logic [1:0] MODE_CCM     = 2'h0;
  localparam logic [1:0] MODE_DEM     = 2'h1;

  typedef enum logic [2:0] {
    BGHC_OFF     = 3'b000,
    BGHC_HS_OFF  = 3'b001,
    BGHC_DT_HL   = 3'b010,
    BGHC_LS_ON   = 3'b011,
    BGHC_LS_OFF  = 3'b100,
    BGHC_DT_LH   = 3'b101,
    BGHC_HS_ON   = 3'b110
  } bghc_state_t;

  // Deglitched monitor inputs, carried together
  typedef struct packed {
    logic enable_undervoltage_in;
    logic boot_uv;
    logic hs_gate_low;
    logic ls_gate_low;
    logic ovp;
  } bghc_mon_t;

  // Gate drive pins: value and output enable
  typedef struct packed {
    logic low_side_gate_out;
    logic low_side_gate_oe;
    logic high_side_gate_out;
    logic high_side_gate_oe;
  } bghc_gate_t;
endpackage : bghc_pkg

// file: logic/bghc_deglitch.sv
// Symmetric deglitch filter for a vector of monitor inputs.
// Assumes inputs already synchronous to clock.
`timescale 1ns/1ps
module bghc_deglitch #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               srst,
  // Raw and filtered vectors
  input  wire logic [WIDTH-1:0]   raw,
  output logic      [WIDTH-1:0]   filt
);
  localparam logic [bghc_pkg::DEGLITCH_W-1:0] LIMIT = bghc_pkg::DEGLITCH_W'(DEPTH);
  logic [bghc_pkg::DEGLITCH_W-1:0] cnt_reg [WIDTH];

  // Same count for both edge directions; one process so filt has a single driver
  always_ff @(posedge clock) begin
    for (int i = 0; i < WIDTH; i++) begin
      if (srst) begin
        cnt_reg[i] <= '0;
        filt[i]    <= 1'b0;
      end else if (raw[i] == filt[i]) begin
        cnt_reg[i] <= '0;
      end else if (cnt_reg[i] + 1'b1 >= LIMIT) begin
        cnt_reg[i] <= '0;
        filt[i]    <= raw[i];
      end else begin
        cnt_reg[i] <= cnt_reg[i] + 1'b1;
      end
    end
  end
endmodule : bghc_deglitch

// file: logic/bghc_phase.sv
// One phase of gate-drive sequencing with adaptive dead time and hiccup.
// Assumes sw_cycle_en pulses once per switching cycle; on_req gives on-time cycles.
`timescale 1ns/1ps
module bghc_phase #(
  parameter int CNT_W        = bghc_pkg::CNT_W,
  parameter int DEGLITCH_LEN = 4
) (
  // Clock and reset
  clock,
  srst,
  // Timing and mode
  sw_cycle_en,
  on_req,
  max_on,
  min_on,
  mode,
  dead_time_cfg,
  // Monitor inputs
  enable_undervoltage_in,
  boot_uv_in,
  hs_gate_low_in,
  ls_gate_low_in,
  ovp_in,
  // Gate pins
  low_side_gate_out,
  low_side_gate_oe,
  high_side_gate_out,
  high_side_gate_oe,
  // Status
  power_good_out,
  power_good_oe,
  soft_start_ground,
  comp_ground,
  regulator_enable,
  hiccup_active
);
  input  wire logic             clock;
  input  wire logic             srst;
  input  wire logic             sw_cycle_en;
  input  wire logic [CNT_W-1:0] on_req;
  input  wire logic [CNT_W-1:0] max_on;
  input  wire logic [CNT_W-1:0] min_on;
  input  wire logic [1:0]       mode;
  input  wire logic [7:0]       dead_time_cfg;
  input  wire logic             enable_undervoltage_in;
  input  wire logic             boot_uv_in;
  input  wire logic             hs_gate_low_in;
  input  wire logic             ls_gate_low_in;
  input  wire logic             ovp_in;
  output logic                  low_side_gate_out;
  output logic                  low_side_gate_oe;
  output logic                  high_side_gate_out;
  output logic                  high_side_gate_oe;
  output logic                  power_good_out;
  output logic                  power_good_oe;
  output logic                  soft_start_ground;
  output logic                  comp_ground;
  output logic                  regulator_enable;
  output logic                  hiccup_active;

  localparam logic [CNT_W-1:0] REPL_LEN = CNT_W'(bghc_pkg::REPLENISH_CYCLES);
  localparam logic [9:0]       HICCUP_N = 10'(bghc_pkg::HICCUP_SW_CYCLES);
  localparam logic [2:0]       PER_SET  = 3'(bghc_pkg::REPL_PER_SET);
  localparam logic [2:0]       SETS     = 3'(bghc_pkg::REPL_SETS);

  bghc_pkg::bghc_mon_t  mon;
  bghc_pkg::bghc_state_t st_reg;
  logic [CNT_W-1:0] tcnt_reg, on_len_reg;
  logic [7:0]       dt_reg;
  logic             dt_loaded_reg, run, repl_reg, bypass_reg;
  logic [2:0]       repl_cnt_reg, set_cnt_reg;
  logic [9:0]       hic_cnt_reg;
  logic [CNT_W-1:0] on_eff;

  bghc_deglitch #(.WIDTH(5), .DEPTH(DEGLITCH_LEN)) u_dg (
    .clock (clock),
    .srst  (srst),
    .raw   ({enable_undervoltage_in, boot_uv_in, hs_gate_low_in, ls_gate_low_in, ovp_in}),
    .filt  (mon)
  );

  function automatic logic [CNT_W-1:0] cap_on(input logic [CNT_W-1:0] req, input logic [CNT_W-1:0] lim,
                                              input logic diode_emulation_mode);
    cap_on = (!diode_emulation_mode && req > lim) ? lim : req;
  endfunction : cap_on

  assign run    = mon.enable_undervoltage_in && !hiccup_active;
  assign on_eff = cap_on(on_req, max_on, mode == bghc_pkg::MODE_DEM);

  // Dead time frozen at start-up so a mid-run change cannot shorten a gap
  always_ff @(posedge clock) begin
    if (srst || !mon.enable_undervoltage_in) begin
      dt_loaded_reg <= 1'b0;
      dt_reg        <= 8'h01;
    end else if (!dt_loaded_reg) begin
      dt_loaded_reg <= 1'b1;
      dt_reg        <= (dead_time_cfg == 8'h00) ? 8'h01 : dead_time_cfg;
    end
  end

  // Replenish and hiccup counters on the switching cycle
  always_ff @(posedge clock) begin
    if (srst || !mon.enable_undervoltage_in) begin
      repl_cnt_reg  <= '0;
      set_cnt_reg   <= '0;
      hic_cnt_reg   <= '0;
      hiccup_active <= 1'b0;
    end else if (sw_cycle_en) begin
      if (hiccup_active) begin
        if (hic_cnt_reg == HICCUP_N - 10'h001) begin
          hiccup_active <= 1'b0;
          hic_cnt_reg   <= '0;
        end else begin
          hic_cnt_reg <= hic_cnt_reg + 10'h001;
        end
      end else if (mon.boot_uv) begin
        if (repl_cnt_reg == PER_SET - 3'h1) begin
          repl_cnt_reg <= '0;
          if (set_cnt_reg == SETS - 3'h1) begin
            set_cnt_reg   <= '0;
            hiccup_active <= 1'b1;
          end else begin
            set_cnt_reg <= set_cnt_reg + 3'h1;
          end
        end else begin
          repl_cnt_reg <= repl_cnt_reg + 3'h1;
        end
      end else begin
        repl_cnt_reg <= '0;
        set_cnt_reg  <= '0;
      end
    end
  end

  // Gate sequencing
  always_ff @(posedge clock) begin
    if (srst || !run) begin
      st_reg     <= bghc_pkg::BGHC_OFF;
      tcnt_reg   <= '0;
      on_len_reg <= '0;
      repl_reg   <= 1'b0;
      bypass_reg <= 1'b0;
    end else begin
      case (st_reg)
        bghc_pkg::BGHC_OFF, bghc_pkg::BGHC_HS_ON: begin
          if (sw_cycle_en && !mon.ovp) begin
            bypass_reg <= 1'b0;
            if (mon.boot_uv) begin
              repl_reg   <= 1'b1;
              on_len_reg <= REPL_LEN;
              st_reg     <= bghc_pkg::BGHC_HS_OFF;
            end else if (on_req == '0) begin
              bypass_reg <= 1'b1;
              // Staying in HS_ON keeps the high side from dipping during bypass
              st_reg     <= (st_reg == bghc_pkg::BGHC_OFF) ? bghc_pkg::BGHC_LS_OFF : bghc_pkg::BGHC_HS_ON;
            end else if (on_eff >= min_on) begin
              repl_reg   <= 1'b0;
              on_len_reg <= on_eff;
              st_reg     <= bghc_pkg::BGHC_HS_OFF;
            end else begin
              st_reg <= (st_reg == bghc_pkg::BGHC_OFF) ? bghc_pkg::BGHC_LS_OFF : bghc_pkg::BGHC_HS_ON;
            end
          end else if (st_reg == bghc_pkg::BGHC_OFF) begin
            st_reg <= bghc_pkg::BGHC_LS_OFF;
          end
        end
        bghc_pkg::BGHC_HS_OFF: begin
          if (mon.hs_gate_low) begin
            tcnt_reg <= '0;
            st_reg   <= bghc_pkg::BGHC_DT_HL;
          end
        end
        bghc_pkg::BGHC_DT_HL: begin
          if (tcnt_reg + 1'b1 >= CNT_W'(dt_reg)) begin
            tcnt_reg <= '0;
            st_reg   <= bghc_pkg::BGHC_LS_ON;
          end else begin
            tcnt_reg <= tcnt_reg + 1'b1;
          end
        end
        bghc_pkg::BGHC_LS_ON: begin
          if (mon.ovp || tcnt_reg + 1'b1 >= on_len_reg) begin
            tcnt_reg <= '0;
            st_reg   <= bghc_pkg::BGHC_LS_OFF;
          end else begin
            tcnt_reg <= tcnt_reg + 1'b1;
          end
        end
        bghc_pkg::BGHC_LS_OFF: begin
          if (mon.ls_gate_low) begin
            tcnt_reg <= '0;
            st_reg   <= bghc_pkg::BGHC_DT_LH;
          end
        end
        bghc_pkg::BGHC_DT_LH: begin
          if (tcnt_reg + 1'b1 >= CNT_W'(dt_reg)) begin
            tcnt_reg <= '0;
            st_reg   <= bghc_pkg::BGHC_HS_ON;
          end else begin
            tcnt_reg <= tcnt_reg + 1'b1;
          end
        end
        default: st_reg <= bghc_pkg::BGHC_OFF;
      endcase
    end
  end

  // Outputs registered; high side on in HS_ON covers bypass and overvoltage
  always_ff @(posedge clock) begin
    if (srst) begin
      low_side_gate_out  <= 1'b0;
      low_side_gate_oe   <= 1'b0;
      high_side_gate_out <= 1'b0;
      high_side_gate_oe  <= 1'b0;
      power_good_out     <= 1'b0;
      power_good_oe      <= 1'b1;
      soft_start_ground  <= 1'b1;
      comp_ground        <= 1'b1;
      regulator_enable   <= 1'b0;
    end else begin
      low_side_gate_out  <= run && st_reg == bghc_pkg::BGHC_LS_ON;
      high_side_gate_out <= run && st_reg == bghc_pkg::BGHC_HS_ON;
      low_side_gate_oe   <= mon.enable_undervoltage_in;
      high_side_gate_oe  <= mon.enable_undervoltage_in;
      power_good_out     <= 1'b0;
      power_good_oe      <= !run;
      soft_start_ground  <= !run;
      comp_ground        <= !mon.enable_undervoltage_in;
      regulator_enable   <= mon.enable_undervoltage_in;
    end
  end

  // Checks
  property p_no_shoot;
    @(posedge clock) disable iff (srst) !(low_side_gate_out && high_side_gate_out);
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("both gates on");
  property p_hl_gap;
    @(posedge clock) disable iff (srst) $rose(low_side_gate_out) |-> $past(st_reg, 2) == bghc_pkg::BGHC_DT_HL;
  endproperty
  a_hl_gap: assert property (p_hl_gap) else $error("low side on without dead time");
  property p_lh_gap;
    @(posedge clock) disable iff (srst) $rose(high_side_gate_out) |-> $past(st_reg, 2) == bghc_pkg::BGHC_DT_LH;
  endproperty
  a_lh_gap: assert property (p_lh_gap) else $error("high side on without dead time");
  property p_hiz;
    @(posedge clock) disable iff (srst) !mon.enable_undervoltage_in |=> !low_side_gate_oe && !high_side_gate_oe;
  endproperty
  a_hiz: assert property (p_hiz) else $error("gates driven in shutdown");
  property p_hic_pg;
    @(posedge clock) disable iff (srst) hiccup_active |=> power_good_oe && soft_start_ground;
  endproperty
  a_hic_pg: assert property (p_hic_pg) else $error("power good not low in hiccup");
  property p_sd;
    @(posedge clock) disable iff (srst) !mon.enable_undervoltage_in |=> comp_ground && !regulator_enable;
  endproperty
  a_sd: assert property (p_sd) else $error("shutdown outputs wrong");
  property p_cnt_clr;
    @(posedge clock) disable iff (srst) !mon.enable_undervoltage_in |=> hic_cnt_reg == '0 && repl_cnt_reg == '0;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("counters not cleared");
  property p_ls_cap;
    @(posedge clock) disable iff (srst) st_reg == bghc_pkg::BGHC_LS_ON |-> tcnt_reg < on_len_reg || mon.ovp;
  endproperty
  a_ls_cap: assert property (p_ls_cap) else $error("on-time over limit");
  property p_hic_stop;
    @(posedge clock) disable iff (srst) hiccup_active |=> !low_side_gate_out;
  endproperty
  a_hic_stop: assert property (p_hic_stop) else $error("switching in hiccup");
  c_hiccup: cover property (@(posedge clock) $rose(hiccup_active));
  c_repl:   cover property (@(posedge clock) $rose(low_side_gate_out) && repl_reg);
  c_bypass: cover property (@(posedge clock) bypass_reg && high_side_gate_out);
endmodule : bghc_phase

// file: verification/bghc_fet_model.sv
// External half-bridge model: reports when each gate has discharged below threshold.
// Assumes a gate that is released or driven low discharges through its pull-down in dly clocks.
`timescale 1ns/1ps
module bghc_fet_model (
  // Clock
  input  wire logic       clock,
  // Gate pins
  input  wire logic       low_side_gate_out,
  input  wire logic       low_side_gate_oe,
  input  wire logic       high_side_gate_out,
  input  wire logic       high_side_gate_oe,
  // Discharge time in clocks, small for a prompt part and large for a slow one
  input  wire logic [7:0] dly,
  // Gate-low detection
  output logic            hs_gate_low,
  output logic            ls_gate_low
);
  logic [7:0] hs_cnt_reg = 8'h00;
  logic [7:0] ls_cnt_reg = 8'h00;
  wire        hs_drv     = high_side_gate_out && high_side_gate_oe;
  wire        ls_drv     = low_side_gate_out && low_side_gate_oe;
  always_ff @(posedge clock) begin
    if (hs_drv) hs_cnt_reg <= 8'h00;
    else if (hs_cnt_reg < dly) hs_cnt_reg <= hs_cnt_reg + 8'h01;
  end
  always_ff @(posedge clock) begin
    if (ls_drv) ls_cnt_reg <= 8'h00;
    else if (ls_cnt_reg < dly) ls_cnt_reg <= ls_cnt_reg + 8'h01;
  end
  // Never reports low while the gate is still charged, so dead time is not shortened
  assign hs_gate_low = !hs_drv && (hs_cnt_reg >= dly);
  assign ls_gate_low = !ls_drv && (ls_cnt_reg >= dly);
endmodule : bghc_fet_model

// file: verification/boost_gate_drive_hiccup_ctrl_tb.sv
// Self-checking bench for one gate-drive phase with a half-bridge model.
// Assumes the controller samples inputs on the rising edge of a 200 MHz clock; the bench drives them on the falling edge.
`timescale 1ns/1ps
module boost_gate_drive_hiccup_ctrl_tb;
  localparam int DT = 3;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        sw_cycle_en = 1'b0;
  logic [15:0] on_req = 16'h0014;
  logic [15:0] max_on = 16'h000c;
  logic [15:0] min_on = 16'h0004;
  logic [1:0]  mode = 2'h0;
  logic        en = 1'b0;
  logic        boot_uv = 1'b0;
  logic        ovp = 1'b0;
  logic        hs_low, ls_low, lo, lo_oe, hi, hi_oe, pg, pg_oe, ss_gnd, comp_gnd, reg_en, hiccup;
  int          errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          w, g, h, o;

  always #2.5 clock = ~clock;

  bghc_phase #(.DEGLITCH_LEN(4)) i_dut (.clock(clock), .srst(srst), .sw_cycle_en(sw_cycle_en), .on_req(on_req),
    .max_on(max_on), .min_on(min_on), .mode(mode), .dead_time_cfg(8'h03), .enable_undervoltage_in(en),
    .boot_uv_in(boot_uv), .hs_gate_low_in(hs_low), .ls_gate_low_in(ls_low), .ovp_in(ovp),
    .low_side_gate_out(lo), .low_side_gate_oe(lo_oe), .high_side_gate_out(hi), .high_side_gate_oe(hi_oe),
    .power_good_out(pg), .power_good_oe(pg_oe), .soft_start_ground(ss_gnd), .comp_ground(comp_gnd),
    .regulator_enable(reg_en), .hiccup_active(hiccup));

  bghc_fet_model i_fet (.clock(clock), .low_side_gate_out(lo), .low_side_gate_oe(lo_oe),
    .high_side_gate_out(hi), .high_side_gate_oe(hi_oe), .dly(8'h02), .hs_gate_low(hs_low), .ls_gate_low(ls_low));

  task automatic chk_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic chk_int(input int got, input int exp, input string what);
    check_count++;
    if (got != exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask : chk_int

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clock);
  endtask : wait_clk

  // One switching cycle: longest low-side pulse, gap after high side off, high-side clocks, overlaps
  task automatic run(input int span, output int width, output int gap, output int hs_on, output int ovl);
    int run_len;
    int last_hi;
    width = 0; gap = -1; hs_on = 0; ovl = 0; run_len = 0; last_hi = -1;
    @(negedge clock);
    sw_cycle_en = 1'b1;
    @(negedge clock);
    sw_cycle_en = 1'b0;
    for (int i = 0; i < span; i++) begin
      if (lo === 1'b1 && hi === 1'b1) ovl++;
      if (hi === 1'b1) hs_on++;
      if (hi === 1'b1) last_hi = i;
      if (lo === 1'b1 && run_len == 0 && gap < 0) gap = i - last_hi - 1;
      run_len = (lo === 1'b1) ? run_len + 1 : 0;
      if (run_len > width) width = run_len;
      @(negedge clock);
    end
  endtask : run

  task automatic set_en(input logic v, input int hold);
    en = v;
    wait_clk(hold);
  endtask : set_en

  task automatic t_shutdown();
    chk_bit(lo_oe, 1'b0, "low gate enable");
    chk_bit(hi_oe, 1'b0, "high gate enable");
    chk_bit(comp_gnd, 1'b1, "comp ground");
    chk_bit(ss_gnd, 1'b1, "soft-start ground");
    chk_bit(pg_oe, 1'b1, "power-good pull-down");
    chk_bit(pg, 1'b0, "power-good level");
    chk_bit(reg_en, 1'b0, "regulator enable");
  endtask : t_shutdown

  task automatic t_deglitch();
    set_en(1'b1, 2);
    set_en(1'b0, 8);
    chk_bit(comp_gnd, 1'b1, "short rising pulse ignored");
    set_en(1'b1, 12);
    chk_bit(comp_gnd, 1'b0, "enabled");
    chk_bit(reg_en, 1'b1, "regulator on");
    chk_bit(lo_oe, 1'b1, "low gate driven");
    chk_bit(hi_oe, 1'b1, "high gate driven");
    set_en(1'b0, 2);
    set_en(1'b1, 8);
    chk_bit(comp_gnd, 1'b0, "short falling pulse ignored");
  endtask : t_deglitch

  task automatic t_ccm_dem();
    run(120, w, g, h, o);
    run(120, w, g, h, o);
    chk_int(w, 12, "duty cap width");
    chk_int(o, 0, "gate overlap");
    chk_bit(g >= DT, 1'b1, "high-to-low dead time");
    chk_bit(hi, 1'b1, "high side back on");
    mode = 2'h1;
    run(120, w, g, h, o);
    chk_int(w, 20, "diode emulation width");
    mode = 2'h0;
  endtask : t_ccm_dem

  task automatic t_skip_bypass();
    on_req = 16'h0003;
    run(120, w, g, h, o);
    chk_int(w, 0, "short pulse skipped");
    on_req = 16'h0000;
    run(120, w, g, h, o);
    chk_int(w, 0, "bypass low side");
    chk_int(h, 120, "bypass high side held");
    on_req = 16'h0014;
  endtask : t_skip_bypass

  task automatic t_ovp();
    ovp = 1'b1;
    wait_clk(10);
    chk_bit(lo, 1'b0, "overvoltage low side");
    chk_bit(hi, 1'b1, "overvoltage high side");
    run(80, w, g, h, o);
    chk_int(w, 0, "no pulse in overvoltage");
    ovp = 1'b0;
    wait_clk(10);
    run(120, w, g, h, o);
    chk_int(w, 12, "resumes after overvoltage");
  endtask : t_ovp

  task automatic t_hiccup();
    boot_uv = 1'b1;
    on_req = 16'h0004;
    wait_clk(8);
    run(80, w, g, h, o);
    chk_int(w, bghc_pkg::REPLENISH_CYCLES, "replenish pulse");
    repeat (7) run(80, w, g, h, o);
    set_en(1'b0, 10);
    set_en(1'b1, 12);
    repeat (15) run(80, w, g, h, o);
    chk_bit(hiccup, 1'b0, "fifteen replenish cycles after shutdown");
    run(80, w, g, h, o);
    chk_bit(hiccup, 1'b1, "hiccup entered");
    chk_bit(pg_oe, 1'b1, "power-good low in hiccup");
    chk_bit(ss_gnd, 1'b1, "soft-start grounded in hiccup");
    boot_uv = 1'b0;
    repeat (bghc_pkg::HICCUP_SW_CYCLES - 1) run(3, w, g, h, o);
    chk_bit(hiccup, 1'b1, "hiccup still off");
    run(3, w, g, h, o);
    chk_bit(hiccup, 1'b0, "hiccup over");
  endtask : t_hiccup

  task automatic stop_test();
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // Run is about 5500 clocks; the ceiling leaves margin
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      $display("CHECK FAILED at %0t: run did not complete", $time);
      stop_test();
    end
  end

  initial begin
    wait_clk(6);
    srst = 1'b0;
    wait_clk(8);
    t_shutdown();
    t_deglitch();
    t_ccm_dem();
    t_skip_bypass();
    t_ovp();
    set_en(1'b0, 10);
    t_shutdown();
    set_en(1'b1, 12);
    t_hiccup();
    stop_test();
  end
endmodule : boost_gate_drive_hiccup_ctrl_tb
